// ### inc/imd_pkg.sv
package imd_pkg;

	localparam logic [7:0]  ADDR_MASK_TOP   = 8'h45;
	localparam logic [7:0]  ADDR_DIV_LOW    = 8'h46;
	localparam logic [7:0]  ADDR_DIV_HIGH   = 8'h47;
	localparam logic [7:0]  ADDR_IRQ_STAT   = 8'h50;
	localparam logic [7:0]  ADDR_IRQ_MASK   = 8'h51;
	localparam logic [7:0]  ADDR_DIV_SEL    = 8'h52;

	localparam logic [7:0]  RST_MASK_TOP    = 8'h00;
	localparam logic [7:0]  RST_DIV_LOW     = 8'hFF;
	localparam logic [7:0]  RST_DIV_HIGH    = 8'h3F;
	localparam logic [7:0]  RST_IRQ_MASK    = 8'h00;
	localparam logic [7:0]  RST_DIV_SEL     = 8'h00;
	localparam logic [7:0]  RST_IRQ_STAT    = 8'h00;

	localparam int          SEC_MASK_BIT    = 6;
	localparam logic [7:0]  MASK_TOP_LIVE   = 8'h40;
	localparam logic [7:0]  DIV_HIGH_LIVE   = 8'h3F;
	localparam int          DIV_W           = 14;

	localparam int          IRQ_SEC_CHG     = 0;
	localparam int          IRQ_DIV_WRAP    = 1;
	localparam logic [7:0]  IRQ_LIVE        = 8'h03;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} imd_wb_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} imd_wb_rsp_t;

endpackage : imd_pkg

// ### rtl/imd_prediv.sv
`timescale 1ns/10ps
module imd_prediv (
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	input  wire logic                      ref_en,
	input  wire logic [imd_pkg::DIV_W-1:0] factor,
	output logic                           div_pulse
);
	import imd_pkg::*;

	logic [DIV_W-1:0] count_ff;

	// Divide by factor plus one: count 0..factor, pulse on the wrap.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count_ff  <= '0;
			div_pulse <= 1'b0;
		end else begin
			div_pulse <= 1'b0;
			if (ref_en) begin
				if (count_ff >= factor) begin
					count_ff  <= '0;
					div_pulse <= 1'b1;
				end else begin
					count_ff <= count_ff + 1'b1;
				end
			end
		end
	end

endmodule : imd_prediv

// ### rtl/imd_regs.sv
// The Wishbone register port was decided locally.
`timescale 1ns/10ps
//
// Contract
// - Mask bit 6 gates secondary-path change interrupt.
// - Mask top byte read/write in bit 6 only, other bits read zero, resets zero.
// - Factor low byte read/write, resets all ones.
// - Factor high six bits, resets 0x3F.
// - Selected input divided by factor plus one.
module imd_regs (
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire imd_pkg::imd_wb_req_t wb_req,
	output imd_pkg::imd_wb_rsp_t      wb_rsp,
	input  wire logic                 secondary_path_state,
	input  wire logic                 ref_in,
	output logic                      div_out_ff,
	output logic                      irq_ff
);
	import imd_pkg::*;

	logic [7:0]       mask_top_ff;
	logic [7:0]       div_low_ff;
	logic [7:0]       div_high_ff;
	logic [7:0]       irq_stat_ff;
	logic [7:0]       irq_mask_ff;
	logic [7:0]       div_sel_ff;
	logic             ack_ff;
	logic [31:0]      rdat_ff;
	logic [1:0]       sec_sync_ff;
	logic             sec_prev_ff;
	logic [1:0]       ref_sync_ff;
	logic             ref_prev_ff;
	logic             wb_hit;
	logic             wb_wr;
	logic             wb_rd;
	logic             lane0;
	logic             sec_chg;
	logic             ref_rise;
	logic             div_pulse;
	logic [DIV_W-1:0] factor;
	logic [7:0]       nxt_rdat;
	logic [7:0]       irq_set;

	assign wb_rsp = '{ack: ack_ff, dat: rdat_ff};

	// One wait state: ack follows the request by one edge, then drops.
	// A write lands at the edge that sees ack high, where the master
	// samples it too, so a request abandoned early writes nothing.
	assign wb_hit = wb_req.cyc && wb_req.stb && !ack_ff;
	assign wb_wr  = wb_req.cyc && wb_req.stb && wb_req.we && ack_ff;
	assign wb_rd  = wb_hit && !wb_req.we;
	assign lane0  = wb_req.sel[0];

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= wb_hit;
		end
	end

	always_comb begin
		case (wb_req.adr)
			ADDR_MASK_TOP: nxt_rdat = mask_top_ff;
			ADDR_DIV_LOW:  nxt_rdat = div_low_ff;
			ADDR_DIV_HIGH: nxt_rdat = div_high_ff;
			ADDR_IRQ_STAT: nxt_rdat = irq_stat_ff;
			ADDR_IRQ_MASK: nxt_rdat = irq_mask_ff;
			ADDR_DIV_SEL:  nxt_rdat = div_sel_ff;
			default:       nxt_rdat = 8'h00;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdat_ff <= 32'h0000_0000;
		end else if (wb_rd) begin
			rdat_ff <= {24'h00_0000, nxt_rdat};
		end
	end

	// Unused bits are never stored, so they always read as zero.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mask_top_ff <= RST_MASK_TOP;
		end else if (wb_wr && lane0 && wb_req.adr == ADDR_MASK_TOP) begin
			mask_top_ff <= wb_req.dat[7:0] & MASK_TOP_LIVE;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			div_low_ff <= RST_DIV_LOW;
		end else if (wb_wr && lane0 && wb_req.adr == ADDR_DIV_LOW) begin
			div_low_ff <= wb_req.dat[7:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			div_high_ff <= RST_DIV_HIGH;
		end else if (wb_wr && lane0 && wb_req.adr == ADDR_DIV_HIGH) begin
			div_high_ff <= wb_req.dat[7:0] & DIV_HIGH_LIVE;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_mask_ff <= RST_IRQ_MASK;
			div_sel_ff  <= RST_DIV_SEL;
		end else if (wb_wr && lane0) begin
			if (wb_req.adr == ADDR_IRQ_MASK) begin
				irq_mask_ff <= wb_req.dat[7:0] & IRQ_LIVE;
			end
			if (wb_req.adr == ADDR_DIV_SEL) begin
				div_sel_ff <= {7'h00, wb_req.dat[0]};
			end
		end
	end

	// Pins come from outside the clock domain, so two flops first.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sec_sync_ff <= 2'h0;
			sec_prev_ff <= 1'b0;
			ref_sync_ff <= 2'h0;
			ref_prev_ff <= 1'b0;
		end else begin
			sec_sync_ff <= {sec_sync_ff[0], secondary_path_state};
			sec_prev_ff <= sec_sync_ff[1];
			ref_sync_ff <= {ref_sync_ff[0], ref_in};
			ref_prev_ff <= ref_sync_ff[1];
		end
	end

	assign sec_chg  = sec_sync_ff[1] ^ sec_prev_ff;
	assign ref_rise = ref_sync_ff[1] && !ref_prev_ff;

	// The factor is read live from both bytes, so the newest pair applies.
	assign factor = {div_high_ff[5:0], div_low_ff};

	imd_prediv u_prediv (
		.clk       (clk),
		.rst_n     (rst_n),
		.ref_en    (ref_rise && div_sel_ff[0]),
		.factor    (factor),
		.div_pulse (div_pulse)
	);

	// Divided output toggles per wrap, giving one full cycle per 2*(factor+1) edges.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			div_out_ff <= 1'b0;
		end else if (div_pulse) begin
			div_out_ff <= !div_out_ff;
		end
	end

	always_comb begin
		irq_set = 8'h00;
		irq_set[IRQ_SEC_CHG]  = sec_chg && mask_top_ff[SEC_MASK_BIT];
		irq_set[IRQ_DIV_WRAP] = div_pulse;
	end

	// A read clears status, but an event landing in that cycle survives.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_stat_ff <= RST_IRQ_STAT;
		end else if (wb_rd && wb_req.adr == ADDR_IRQ_STAT) begin
			irq_stat_ff <= irq_set;
		end else begin
			irq_stat_ff <= irq_stat_ff | irq_set;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(irq_stat_ff & irq_mask_ff);
		end
	end

	AST_SEC_MASKED: assert property (@(posedge clk) disable iff (!rst_n)
		!mask_top_ff[SEC_MASK_BIT] |=> !irq_stat_ff[IRQ_SEC_CHG] ||
			$past(irq_stat_ff[IRQ_SEC_CHG]))
		else $error("masked secondary change set status");

	AST_SEC_UNMASKED: assert property (@(posedge clk) disable iff (!rst_n)
		sec_chg && mask_top_ff[SEC_MASK_BIT] |=> irq_stat_ff[IRQ_SEC_CHG])
		else $error("unmasked secondary change lost");

	AST_MASK_RESV: assert property (@(posedge clk) disable iff (!rst_n)
		(mask_top_ff & ~MASK_TOP_LIVE) == 8'h00)
		else $error("mask top unused bit set");

	AST_MASK_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
		wb_wr && lane0 && wb_req.adr == ADDR_MASK_TOP |=>
			mask_top_ff == ($past(wb_req.dat[7:0]) & MASK_TOP_LIVE))
		else $error("mask top write not stored");

	AST_LOW_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
		wb_wr && lane0 && wb_req.adr == ADDR_DIV_LOW |=>
			div_low_ff == $past(wb_req.dat[7:0]))
		else $error("factor low write not stored");

	AST_HIGH_RESV: assert property (@(posedge clk) disable iff (!rst_n)
		div_high_ff[7:6] == 2'h0)
		else $error("factor high unused bits set");

	AST_HIGH_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
		wb_wr && lane0 && wb_req.adr == ADDR_DIV_HIGH |=>
			div_high_ff == ($past(wb_req.dat[7:0]) & DIV_HIGH_LIVE))
		else $error("factor high write not stored");

	AST_DIV_TOGGLE: assert property (@(posedge clk) disable iff (!rst_n)
		div_pulse |=> div_out_ff != $past(div_out_ff))
		else $error("divided output did not toggle");

	AST_FACTOR: assert property (@(posedge clk) disable iff (!rst_n)
		wb_wr && lane0 && wb_req.adr == ADDR_DIV_HIGH |=>
			factor == {$past(wb_req.dat[5:0]), $past(div_low_ff)})
		else $error("factor not formed from both bytes");

	AST_ACK_ONE: assert property (@(posedge clk) disable iff (!rst_n)
		ack_ff |=> !ack_ff)
		else $error("ack held two cycles");

	AST_MASK_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
		!(wb_wr && lane0 && wb_req.adr == ADDR_MASK_TOP) |=>
			$stable(mask_top_ff))
		else $error("mask top changed without a write");

	AST_LOW_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
		!(wb_wr && lane0 && wb_req.adr == ADDR_DIV_LOW) |=>
			$stable(div_low_ff))
		else $error("factor low changed without a write");

	AST_HIGH_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
		!(wb_wr && lane0 && wb_req.adr == ADDR_DIV_HIGH) |=>
			$stable(div_high_ff))
		else $error("factor high changed without a write");

	AST_MASK_READ: assert property (@(posedge clk) disable iff (!rst_n)
		wb_rd && wb_req.adr == ADDR_MASK_TOP |=>
			wb_rsp.dat == {24'h00_0000, $past(mask_top_ff)})
		else $error("mask top read wrong");

	AST_LOW_READ: assert property (@(posedge clk) disable iff (!rst_n)
		wb_rd && wb_req.adr == ADDR_DIV_LOW |=>
			wb_rsp.dat == {24'h00_0000, $past(div_low_ff)})
		else $error("factor low read wrong");

	AST_HIGH_READ: assert property (@(posedge clk) disable iff (!rst_n)
		wb_rd && wb_req.adr == ADDR_DIV_HIGH |=>
			wb_rsp.dat == {24'h00_0000, $past(div_high_ff)})
		else $error("factor high read wrong");

	AST_FACT_LOW: assert property (@(posedge clk) disable iff (!rst_n)
		wb_wr && lane0 && wb_req.adr == ADDR_DIV_LOW |=>
			factor == {$past(div_high_ff[5:0]), $past(wb_req.dat[7:0])})
		else $error("factor low write not applied");

	AST_DIV_QUIET: assert property (@(posedge clk) disable iff (!rst_n)
		!div_sel_ff[0] |=> !div_pulse)
		else $error("divider ran while deselected");

	AST_SEC_SILENT: assert property (@(posedge clk) disable iff (!rst_n)
		!mask_top_ff[SEC_MASK_BIT] |-> !irq_set[IRQ_SEC_CHG])
		else $error("masked secondary change raised an event");

	AST_STAT_SET: assert property (@(posedge clk) disable iff (!rst_n)
		irq_set != 8'h00 |=>
			(irq_stat_ff & $past(irq_set)) == $past(irq_set))
		else $error("event did not set status");

	AST_STAT_CLR: assert property (@(posedge clk) disable iff (!rst_n)
		wb_rd && wb_req.adr == ADDR_IRQ_STAT |=>
			irq_stat_ff == $past(irq_set))
		else $error("status read did not clear");

	AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (!rst_n)
		irq_ff == $past(|(irq_stat_ff & irq_mask_ff)))
		else $error("interrupt level wrong");

	AST_ACK_ANSWER: assert property (@(posedge clk) disable iff (!rst_n)
		wb_hit |=> ack_ff)
		else $error("request not acknowledged");

	AST_RD_UPPER: assert property (@(posedge clk) disable iff (!rst_n)
		ack_ff |-> wb_rsp.dat[31:8] == 24'h00_0000)
		else $error("read data upper bits set");

	COV_MASK_WR: cover property (@(posedge clk) disable iff (!rst_n)
		wb_wr && wb_req.adr == ADDR_MASK_TOP);
	COV_SEC_IRQ: cover property (@(posedge clk) disable iff (!rst_n)
		irq_stat_ff[IRQ_SEC_CHG] && irq_ff);
	COV_DIV_PULSE: cover property (@(posedge clk) disable iff (!rst_n)
		div_pulse);
	COV_STAT_CLR: cover property (@(posedge clk) disable iff (!rst_n)
		wb_rd && wb_req.adr == ADDR_IRQ_STAT && irq_stat_ff != 8'h00);

endmodule : imd_regs

// ### tb/test_irq_mask_and_input_divider_cfg.sv
`timescale 1ns/10ps
module test_irq_mask_and_input_divider_cfg;
	import imd_pkg::*;
	logic        clk;
	logic        rst_n;
	imd_wb_req_t wb_req;
	imd_wb_rsp_t wb_rsp;
	logic        sec_state;
	logic        ref_in;
	logic        div_out;
	logic        irq;
	int          n_fail;
	int          checks_done;
	int          ref_edges;
	logic [7:0]  rd;

	imd_regs DUT (
		.clk                  (clk),
		.rst_n                (rst_n),
		.wb_req               (wb_req),
		.wb_rsp               (wb_rsp),
		.secondary_path_state (sec_state),
		.ref_in               (ref_in),
		.div_out_ff           (div_out),
		.irq_ff               (irq)
	);

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// The reference runs free so the divider always sees rising edges.
	always @(posedge clk) begin
		ref_in <= ~ref_in;
		if (!ref_in)
			ref_edges <= ref_edges + 1;
	end

	task summarize;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : summarize

	task cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp

	task wb_cycle(input logic we, input logic [7:0] adr, input logic [7:0] wd);
		int n;
		@(posedge clk);
		wb_req <= '{1'b1, 1'b1, we, adr, 4'hF, {24'h000000, wd}};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wb_rsp.ack !== 1'b1 && n < 20);
		cmp("ack", 16'h0001, {15'h0000, wb_rsp.ack});
		rd = wb_rsp.dat[7:0];
		wb_req <= '0;
	endtask : wb_cycle

	task chk(input logic [7:0] adr, input logic [7:0] exp);
		wb_cycle(1'b0, adr, 8'h00);
		cmp($sformatf("reg %h", adr), {8'h00, exp}, {8'h00, rd});
	endtask : chk

	task toggle_sec;
		@(posedge clk);
		sec_state <= ~sec_state;
		repeat (6) @(posedge clk);
	endtask : toggle_sec

	// The first interval after a factor change is partial, so the second
	// one is the one measured.
	task measure(input logic [15:0] exp);
		int a;
		int n;
		logic d;
		for (int k = 0; k < 2; k++) begin
			a = ref_edges;
			d = div_out;
			n = 0;
			while (div_out === d && n < 3000) begin
				@(posedge clk);
				n++;
			end
		end
		cmp("ref edges per toggle", exp, 16'(ref_edges - a));
	endtask : measure

	initial begin
		#5000000;
		n_fail++;
		$display("watchdog expired");
		summarize();
	end

	initial begin
		rst_n = 1'b0;
		wb_req = '0;
		sec_state = 1'b0;
		ref_in = 1'b0;
		ref_edges = 0;
		n_fail = 0;
		checks_done = 0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		chk(8'h45, 8'h00);
		chk(8'h46, 8'hFF);
		chk(8'h47, 8'h3F);
		chk(8'h30, 8'h00);
		chk(8'h50, 8'h00);
		chk(8'h51, 8'h00);
		chk(8'h52, 8'h00);
		$display("test reset values done");
		wb_cycle(1'b1, 8'h45, 8'hFF);
		chk(8'h45, 8'h40);
		wb_cycle(1'b1, 8'h47, 8'hFF);
		chk(8'h47, 8'h3F);
		wb_cycle(1'b1, 8'h46, 8'h5A);
		chk(8'h46, 8'h5A);
		wb_cycle(1'b1, 8'h30, 8'hFF);
		chk(8'h30, 8'h00);
		$display("test access done");
		wb_cycle(1'b1, 8'h45, 8'h00);
		wb_cycle(1'b1, 8'h51, 8'h01);
		toggle_sec();
		cmp("irq", 16'h0000, {15'h0000, irq});
		chk(8'h50, 8'h00);
		wb_cycle(1'b1, 8'h45, 8'h40);
		toggle_sec();
		cmp("irq", 16'h0001, {15'h0000, irq});
		chk(8'h50, 8'h01);
		repeat (3) @(posedge clk);
		cmp("irq", 16'h0000, {15'h0000, irq});
		wb_cycle(1'b1, 8'h51, 8'h00);
		toggle_sec();
		cmp("irq", 16'h0000, {15'h0000, irq});
		chk(8'h50, 8'h01);
		$display("test interrupt done");
		wb_cycle(1'b1, 8'h46, 8'h02);
		wb_cycle(1'b1, 8'h47, 8'h00);
		wb_cycle(1'b1, 8'h52, 8'h01);
		measure(16'h0003);
		chk(8'h50, 8'h02);
		wb_cycle(1'b1, 8'h47, 8'h01);
		measure(16'h0103);
		wb_cycle(1'b1, 8'h52, 8'h00);
		$display("test divider done");
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		chk(8'h45, 8'h00);
		chk(8'h46, 8'hFF);
		chk(8'h47, 8'h3F);
		chk(8'h52, 8'h00);
		cmp("div_out", 16'h0000, {15'h0000, div_out});
		$display("test mid-run reset done");
		summarize();
	end
endmodule : test_irq_mask_and_input_divider_cfg
